/* rtl/prc_regs.vh */
// register map, field layout, reset values and timing constants of the pulse rate converter
`ifndef PRC_REGS_VH
`define PRC_REGS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PRC_CTRL 12'h000
`define PRC_FULLFREQ 12'h004
`define PRC_ZEROFREQ 12'h008
`define PRC_LOWCUT 12'h00C
`define PRC_SAMPTIME 12'h010
`define PRC_ALMSET 12'h014
`define PRC_ALMHYST 12'h018
`define PRC_ALMONDLY 12'h01C
`define PRC_ALMOFFDLY 12'h020
`define PRC_TRIM 12'h024
`define PRC_STATUS 12'h028
`define PRC_MEASFREQ 12'h02C
// ----------------------------------------
// control fields
// ----------------------------------------
`define PRC_B_INTEG 0
`define PRC_B_AUTOSAMP 1
`define PRC_B_FILTER 2
`define PRC_B_HIGH1 3
`define PRC_B_HIGH2 4
`define PRC_B_ENERG1 5
`define PRC_B_ENERG2 6
`define PRC_B_TRIM_BIPOLAR 16
// ----------------------------------------
// reset values (frequencies in 0.01 Hz, levels in 0.1 %)
// ----------------------------------------
`define PRC_CTRL_RST 32'h0001_130A
`define PRC_FULL_RST 24'h00_03E8
`define PRC_ZERO_RST 24'h00_0000
`define PRC_LOWCUT_RST 24'h00_0001
`define PRC_SAMP_RST 10'h064
`define PRC_ALMSET_RST 32'h0000_03E8
`define PRC_ALMHYST_RST 32'h001E_001E
// ----------------------------------------
// scaling and timing
// ----------------------------------------
// at 200 MHz: 100 ms tick, 20 s timeout, 10 ms / 8 filter, clock x 100 in 0.01 Hz
`define PRC_TICK_CYC 32'h0131_2D00
`define PRC_TIMEOUT_CYC 33'h0_EE6B_2800
`define PRC_FILTER_CYC 24'h03_D090
`define PRC_FREQ_NUM 40'h04_A817_C800
`define PRC_FULL_PCT 11'd1000
`define PRC_AUTO_NUM 40'd100000
`define PRC_AUTO_FAST 24'd100000
`define PRC_AUTO_SLOW 24'd100
`define PRC_SAMP_MAX 10'd1000
`define PRC_ON_MARGIN 14'd2
`define PRC_DIV_STEPS 6'd40
`define PRC_SPAN_LIM 8'sd100
`define PRC_SPAN_LIM_BI 8'sd50
`define PRC_ZERO_LIM 8'sd50
`endif

/* rtl/prc_core.v */
// pulse rate converter core: pulse capture, frequency, scaling, alarms, apb registers
`include "prc_regs.vh"
module prc_core #(
  parameter [31:0] TICK_CYC = `PRC_TICK_CYC,
  parameter [32:0] TIMEOUT_CYC = `PRC_TIMEOUT_CYC,
  parameter [23:0] FILTER_CYC = `PRC_FILTER_CYC
) (
  // clock and reset
  input wire mclk,
  input wire reset,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // field pulse input, high while on
  input wire pulseIn,
  // analog level out, signed, 0.1 % units
  output reg [15:0] outLevel,
  output reg outUpdate,
  // alarm relays and indicators
  output wire [1:0] relayDrive,
  output wire [1:0] alarmLed,
  // serial link configuration
  output wire [1:0] linkBaudSel,
  output wire linkSevenBits,
  output wire linkTwoStop,
  output wire [1:0] linkParity,
  output wire [1:0] linkProtocol,
  output wire [4:0] linkAddress
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [31:0] ctrl;
  reg [23:0] fullFreq;
  reg [23:0] zeroFreq;
  reg [23:0] lowcut;
  reg [9:0] sampTime;
  reg [31:0] almSet;
  reg [31:0] almHyst;
  reg [31:0] almOnDly;
  reg [31:0] almOffDly;
  reg [16:0] trim;
  reg [23:0] measFreq;
  reg [15:0] rawLevel;
  wire [1:0] alarm;

  wire wrEn = psel & penable & pwrite;
  wire setup = psel & ~penable;
  reg mapped;
  reg [31:0] rdVal;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always @*
  begin
    mapped = 1'b1;
    rdVal = 32'h0000_0000;
    case (paddr)
      `PRC_CTRL: rdVal = ctrl;
      `PRC_FULLFREQ: rdVal = {8'h00, fullFreq};
      `PRC_ZEROFREQ: rdVal = {8'h00, zeroFreq};
      `PRC_LOWCUT: rdVal = {8'h00, lowcut};
      `PRC_SAMPTIME: rdVal = {22'h00_0000, sampTime};
      `PRC_ALMSET: rdVal = almSet;
      `PRC_ALMHYST: rdVal = almHyst;
      `PRC_ALMONDLY: rdVal = almOnDly;
      `PRC_ALMOFFDLY: rdVal = almOffDly;
      `PRC_TRIM: rdVal = {15'h0000, trim};
      `PRC_STATUS: rdVal = {14'h0000, alarm, outLevel};
      `PRC_MEASFREQ: rdVal = {8'h00, measFreq};
      default: mapped = 1'b0;
    endcase
  end

  always @(posedge mclk)
  begin
    if (reset)
    begin
      prdata <= 32'h0000_0000;
      ctrl <= `PRC_CTRL_RST;
      fullFreq <= `PRC_FULL_RST;
      zeroFreq <= `PRC_ZERO_RST;
      lowcut <= `PRC_LOWCUT_RST;
      sampTime <= `PRC_SAMP_RST;
      almSet <= `PRC_ALMSET_RST;
      almHyst <= `PRC_ALMHYST_RST;
      almOnDly <= 32'h0000_0000;
      almOffDly <= 32'h0000_0000;
      trim <= 17'h0_0000;
    end
    else
    begin
      if (setup)
        prdata <= rdVal;
      if (wrEn)
      begin
        case (paddr)
          `PRC_CTRL: ctrl <= {11'h000, pwdata[20:0]};
          `PRC_FULLFREQ: fullFreq <= pwdata[23:0];
          `PRC_ZEROFREQ: zeroFreq <= pwdata[23:0];
          `PRC_LOWCUT: lowcut <= pwdata[23:0];
          `PRC_SAMPTIME: sampTime <= pwdata[9:0];
          `PRC_ALMSET: almSet <= {6'h00, pwdata[25:16], 6'h00, pwdata[9:0]};
          `PRC_ALMHYST: almHyst <= {6'h00, pwdata[25:16], 6'h00, pwdata[9:0]};
          `PRC_ALMONDLY: almOnDly <= {6'h00, pwdata[25:16], 6'h00, pwdata[9:0]};
          `PRC_ALMOFFDLY: almOffDly <= {6'h00, pwdata[25:16], 6'h00, pwdata[9:0]};
          `PRC_TRIM: trim <= pwdata[16:0];
          default: ;
        endcase
      end
    end
  end

  assign linkBaudSel = ctrl[9:8];
  assign linkSevenBits = ctrl[10];
  assign linkTwoStop = ctrl[11];
  assign linkParity = ctrl[13:12];
  assign linkProtocol = ctrl[15:14];
  assign linkAddress = ctrl[20:16];

  // ----------------------------------------
  // input filter and edge detect
  // ----------------------------------------
  reg [23:0] filtCnt;
  reg filtOut;
  reg pulsePrev;
  wire pulseLvl = ctrl[`PRC_B_FILTER] ? filtOut : pulseIn;
  wire pulseEdge = pulseLvl & ~pulsePrev;

  always @(posedge mclk)
  begin
    if (reset)
    begin
      filtCnt <= 24'h00_0000;
      filtOut <= 1'b0;
      pulsePrev <= 1'b0;
    end
    else
    begin
      pulsePrev <= pulseLvl;
      // integrating filter with hysteresis at both ends
      if (pulseIn && filtCnt != FILTER_CYC)
        filtCnt <= filtCnt + 24'h00_0001;
      else if (!pulseIn && filtCnt != 24'h00_0000)
        filtCnt <= filtCnt - 24'h00_0001;
      if (filtCnt == FILTER_CYC)
        filtOut <= 1'b1;
      else if (filtCnt == 24'h00_0000)
        filtOut <= 1'b0;
    end
  end

  // ----------------------------------------
  // 100 ms tick, period and window counters
  // ----------------------------------------
  reg [31:0] tickCnt;
  reg tick;
  reg [32:0] periodCnt;
  reg havePrev;
  reg [23:0] pulseCnt;
  reg [9:0] winTicks;
  reg [9:0] autoT;
  reg [32:0] measRaw;
  reg measPend;
  reg measTake;
  wire integ = ctrl[`PRC_B_INTEG];
  wire [9:0] sampSel = ctrl[`PRC_B_AUTOSAMP] ? autoT : sampTime;
  wire [9:0] sampT = (sampSel == 10'h000) ? 10'h001 : sampSel;

  always @(posedge mclk)
  begin
    if (reset)
    begin
      tickCnt <= 32'h0000_0000;
      tick <= 1'b0;
      periodCnt <= 33'h0_0000_0000;
      havePrev <= 1'b0;
      pulseCnt <= 24'h00_0000;
      winTicks <= 10'h000;
      measRaw <= 33'h0_0000_0000;
      measPend <= 1'b0;
    end
    else
    begin
      tick <= (tickCnt == TICK_CYC - 32'h0000_0001);
      tickCnt <= (tickCnt == TICK_CYC - 32'h0000_0001) ? 32'h0000_0000 :
                 tickCnt + 32'h0000_0001;
      if (measTake)
        measPend <= 1'b0;
      // direct mode: period between on-transitions
      if (pulseEdge)
      begin
        periodCnt <= 33'h0_0000_0000;
        havePrev <= 1'b1;
        if (havePrev && !integ)
        begin
          measRaw <= periodCnt + 33'h0_0000_0001;
          measPend <= 1'b1;
        end
      end
      else if (periodCnt >= TIMEOUT_CYC)
      begin
        periodCnt <= 33'h0_0000_0000;
        havePrev <= 1'b0;
        if (!integ)
        begin
          measRaw <= 33'h0_0000_0000;
          measPend <= 1'b1;
        end
      end
      else
        periodCnt <= periodCnt + 33'h0_0000_0001;
      // integration mode: pulses over the sampling window
      if (tick && winTicks + 10'h001 >= sampT)
      begin
        winTicks <= 10'h000;
        pulseCnt <= 24'h00_0000;
        if (integ)
        begin
          measRaw <= {9'h000, pulseCnt + {23'h00_0000, pulseEdge}};
          measPend <= 1'b1;
        end
      end
      else
      begin
        if (tick)
          winTicks <= winTicks + 10'h001;
        if (pulseEdge)
          pulseCnt <= pulseCnt + 24'h00_0001;
      end
    end
  end

  // ----------------------------------------
  // shared divider and scaling sequence
  // ----------------------------------------
  localparam [4:0] S_TIME = 5'b00001;
  localparam [4:0] S_IDLE = 5'b00010;
  localparam [4:0] S_FREQ = 5'b00100;
  localparam [4:0] S_RAW = 5'b01000;
  localparam [4:0] S_LVL = 5'b10000;

  reg [4:0] state;
  reg divRun;
  reg [5:0] divCnt;
  reg [39:0] divQ;
  reg [32:0] divRem;
  reg [32:0] divDen;
  reg [39:0] next_num;
  reg [32:0] next_den;
  wire [33:0] divTry = {divRem, divQ[39]};
  wire divFits = divTry >= {1'b0, divDen};
  wire [23:0] freqCut = (divQ[39:24] != 16'h0000) ? 24'hFF_FFFF : divQ[23:0];
  wire [23:0] fSpan = fullFreq - zeroFreq;
  wire [23:0] fAbove = (measFreq > zeroFreq) ? measFreq - zeroFreq : 24'h00_0000;
  wire signed [7:0] spanRaw = trim[15:8];
  wire signed [7:0] zeroRaw = trim[7:0];
  wire signed [7:0] spanLim = trim[`PRC_B_TRIM_BIPOLAR] ? `PRC_SPAN_LIM_BI : `PRC_SPAN_LIM;
  wire signed [7:0] spanTrim = (spanRaw > spanLim) ? spanLim :
                               (spanRaw < -spanLim) ? -spanLim : spanRaw;
  wire signed [7:0] zeroTrim = (zeroRaw > `PRC_ZERO_LIM) ? `PRC_ZERO_LIM :
                               (zeroRaw < -`PRC_ZERO_LIM) ? -`PRC_ZERO_LIM : zeroRaw;
  wire [10:0] spanMul = `PRC_FULL_PCT + {{3{spanTrim[7]}}, spanTrim};
  wire [15:0] qSat = (divQ[39:15] != 25'h000_0000) ? 16'h7FFF : divQ[15:0];
  wire [15:0] lvlTrim = qSat + {{8{zeroTrim[7]}}, zeroTrim};

  always @*
  begin
    next_num = 40'h00_0000_0000;
    next_den = 33'h0_0000_0000;
    case (state)
      S_TIME:
      begin
        next_num = `PRC_AUTO_NUM;
        next_den = {9'h000, fullFreq};
      end
      S_FREQ:
      begin
        if (integ)
        begin
          next_num = measRaw[23:0] * 40'd1000;
          next_den = {23'h00_0000, sampT};
        end
        else
        begin
          next_num = `PRC_FREQ_NUM;
          next_den = measRaw;
        end
      end
      S_RAW:
      begin
        next_num = fAbove * 40'd1000;
        next_den = {9'h000, fSpan};
      end
      S_LVL:
      begin
        next_num = fAbove * {29'h0000_0000, spanMul};
        next_den = {9'h000, fSpan};
      end
      default: ;
    endcase
  end

  always @*
    measTake = (state == S_IDLE) && measPend;

  always @(posedge mclk)
  begin
    if (reset)
    begin
      state <= S_TIME;
      divRun <= 1'b0;
      divCnt <= 6'h00;
      divQ <= 40'h00_0000_0000;
      divRem <= 33'h0_0000_0000;
      divDen <= 33'h0_0000_0000;
      autoT <= `PRC_SAMP_MAX;
      measFreq <= 24'h00_0000;
      rawLevel <= 16'h0000;
      outLevel <= 16'h0000;
      outUpdate <= 1'b0;
    end
    else
    begin
      outUpdate <= 1'b0;
      if (state == S_IDLE)
      begin
        state <= measPend ? S_FREQ : S_TIME;
      end
      else if (!divRun)
      begin
        divRun <= 1'b1;
        divCnt <= `PRC_DIV_STEPS;
        divQ <= next_num;
        divRem <= 33'h0_0000_0000;
        divDen <= next_den;
      end
      else if (divCnt != 6'h00)
      begin
        divCnt <= divCnt - 6'h01;
        divRem <= divFits ? divTry[32:0] - divDen : divTry[32:0];
        divQ <= {divQ[38:0], divFits};
      end
      else
      begin
        divRun <= 1'b0;
        case (state)
          S_TIME:
          begin
            if (fullFreq >= `PRC_AUTO_FAST)
              autoT <= 10'h001;
            else if (fullFreq <= `PRC_AUTO_SLOW)
              autoT <= `PRC_SAMP_MAX;
            else
              autoT <= divQ[9:0];
            state <= S_IDLE;
          end
          S_FREQ:
          begin
            // zero divisor means no pulse seen: frequency zero
            if (divDen == 33'h0_0000_0000 || freqCut < lowcut)
              measFreq <= 24'h00_0000;
            else
              measFreq <= freqCut;
            state <= S_RAW;
          end
          S_RAW:
          begin
            rawLevel <= (divDen == 33'h0_0000_0000) ? 16'h0000 : qSat;
            state <= S_LVL;
          end
          S_LVL:
          begin
            if (divDen == 33'h0_0000_0000)
              outLevel <= {{8{zeroTrim[7]}}, zeroTrim};
            else
              outLevel <= lvlTrim;
            outUpdate <= 1'b1;
            state <= S_IDLE;
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // alarms
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : alm
      reg cond;
      reg active;
      reg [13:0] dly;
      wire high = ctrl[`PRC_B_HIGH1 + i];
      wire energNormal = ctrl[`PRC_B_ENERG1 + i];
      wire [15:0] setp = {6'h00, almSet[i*16 +: 10]};
      wire [15:0] hyst = {6'h00, almHyst[i*16 +: 10]};
      wire [13:0] onT = almOnDly[i*16 +: 10] * 14'd10 + `PRC_ON_MARGIN;
      wire [13:0] offT = almOffDly[i*16 +: 10] * 14'd10;
      wire [13:0] target = cond ? onT : offT;
      always @(posedge mclk)
      begin
        if (reset)
        begin
          cond <= 1'b0;
          active <= 1'b0;
          dly <= 14'h0000;
        end
        else
        begin
          if (high)
          begin
            if (!cond && rawLevel >= setp)
              cond <= 1'b1;
            else if (cond && rawLevel + hyst < setp)
              cond <= 1'b0;
          end
          else
          begin
            if (!cond && rawLevel <= setp)
              cond <= 1'b1;
            else if (cond && rawLevel > setp + hyst)
              cond <= 1'b0;
          end
          if (cond == active)
            dly <= 14'h0000;
          else if (dly >= target)
          begin
            active <= cond;
            dly <= 14'h0000;
          end
          else if (tick)
            dly <= dly + 14'h0001;
        end
      end
      assign alarm[i] = active;
      assign relayDrive[i] = active ^ energNormal;
      assign alarmLed[i] = active;
    end
  endgenerate

endmodule

/* bench/prc_core_monitor.sv */
// assertion checker bound to the pulse rate converter core
`include "prc_regs.vh"
module prc_core_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // level output
  input wire logic [15:0] outLevel,
  input wire logic outUpdate,
  // alarms
  input wire logic [1:0] relayDrive,
  input wire logic [1:0] alarmLed,
  // link configuration
  input wire logic [1:0] linkBaudSel,
  input wire logic linkSevenBits,
  input wire logic linkTwoStop,
  input wire logic [1:0] linkParity,
  input wire logic [1:0] linkProtocol,
  input wire logic [4:0] linkAddress
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ctrlCopy;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // ----------------------------------------
  // shadow of the control word
  // ----------------------------------------
  always_ff @(posedge mclk)
    if (reset)
      ctrlCopy <= `PRC_CTRL_RST;
    else if (psel && penable && pwrite && paddr == `PRC_CTRL)
      ctrlCopy <= pwdata;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_link_cfg: assert property ({linkAddress, linkProtocol, linkParity, linkTwoStop,
    linkSevenBits, linkBaudSel} == ctrlCopy[20:8])
    else $error("link config differs from control word");
  chk_relay_map: assert property ($stable(ctrlCopy) && $stable(alarmLed) ##1
    $stable(ctrlCopy) && $stable(alarmLed) && $stable(relayDrive)
    |-> relayDrive == (alarmLed ^ ctrlCopy[6:5]))
    else $error("relay drive does not follow alarm and polarity");
  chk_err_unmapped: assert property (psel && penable && paddr > `PRC_MEASFREQ |-> pslverr)
    else $error("no error on unmapped address");
  chk_err_mapped: assert property (psel && penable && paddr <= `PRC_MEASFREQ
    && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("error on mapped address");
  chk_err_idle: assert property (!penable |-> !pslverr)
    else $error("error outside access phase");
  chk_rdata_hold: assert property (!$past(psel && !penable) |-> $stable(prdata))
    else $error("read data moved during access");
  chk_update_pulse: assert property (outUpdate |=> !outUpdate)
    else $error("update strobe longer than one cycle");
  chk_level_cause: assert property (!$stable(outLevel) |-> outUpdate)
    else $error("level changed without update strobe");
  chk_reset_clear: assert property ($past(reset) |-> outLevel == 16'h0000
    && alarmLed == 2'b00 && !outUpdate)
    else $error("outputs not cleared by reset");
  cov_update: cover property (outUpdate);
  cov_alarm_on: cover property ($rose(alarmLed[0]));
  cov_alarm_off: cover property ($fell(alarmLed[0]));
  cov_bad_addr: cover property (psel && penable && pslverr);
endmodule
bind prc_core prc_core_monitor chk (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .outLevel, .outUpdate, .relayDrive, .alarmLed, .linkBaudSel,
  .linkSevenBits, .linkTwoStop, .linkParity, .linkProtocol, .linkAddress);

/* bench/prc_pulse_source.sv */
// field pulse source driving the converter input
module prc_pulse_source (
  // clock
  input wire logic mclk,
  // pulse shape in cycles, period zero keeps the line off
  input wire logic [15:0] period,
  input wire logic [15:0] highCycles,
  // field line, high while on
  output logic pulseIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] phase = 16'h0000;
  initial pulseIn = 1'b0;
  always @(posedge mclk)
  begin
    if (period == 16'h0000 || phase >= period - 16'h0001)
      phase <= 16'h0000;
    else
      phase <= phase + 16'h0001;
    pulseIn <= (period != 16'h0000) && (phase < highCycles);
  end
endmodule

/* bench/prc_core_bench.sv */
// self-checking bench for the pulse rate converter core
`include "prc_regs.vh"
module prc_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, reset, psel, penable, pwrite, pready, pslverr, pulseIn, outUpdate, lastErr;
  logic linkSevenBits, linkTwoStop;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] outLevel, period, highCycles;
  logic [1:0] relayDrive, alarmLed, linkBaudSel, linkParity, linkProtocol;
  logic [4:0] linkAddress;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  int t0, k, i, j;
  logic [11:0] rstAddr [8] = '{`PRC_CTRL, `PRC_FULLFREQ, `PRC_ZEROFREQ, `PRC_LOWCUT,
    `PRC_SAMPTIME, `PRC_ALMSET, `PRC_ALMHYST, 12'h030};
  logic [31:0] rstVal [8] = '{32'h0001_130A, 32'h0000_03E8, 32'h0000_0000, 32'h0000_0001,
    32'h0000_0064, 32'h0000_03E8, 32'h001E_001E, 32'h0000_0000};
  logic [11:0] dirAddr [8] = '{`PRC_FULLFREQ, `PRC_ZEROFREQ, `PRC_ZEROFREQ, `PRC_LOWCUT,
    `PRC_LOWCUT, `PRC_TRIM, `PRC_TRIM, `PRC_TRIM};
  logic [31:0] dirVal [8] = '{32'h0098_9680, 32'h0026_25A0, 32'h0000_0000, 32'h005B_8D80,
    32'h0000_0001, 32'h0000_7F7F, 32'h0001_7F7F, 32'h0000_0000};
  logic [15:0] dirLevel [8] = '{16'h01F4, 16'h014D, 16'h01F4, 16'h0000, 16'h01F4, 16'h0258,
    16'h023F, 16'h01F4};
  logic [31:0] intCtrl [3] = '{32'h0001_1329, 32'h0001_132B, 32'h0001_132B};
  logic [31:0] intFull [3] = '{32'h0000_0FA0, 32'h0000_C350, 32'h0001_86A0};
  logic [15:0] intLevel [3] = '{16'h01F4, 16'h0028, 16'h0014};
  int intTicks [3] = '{2, 2, 1};
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  prc_core #(.TICK_CYC(32'h0000_00C8), .TIMEOUT_CYC(33'h0_0000_4E20), .FILTER_CYC(24'h00_0014))
  DUT (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulseIn(pulseIn), .outLevel(outLevel), .outUpdate(outUpdate), .relayDrive(relayDrive),
    .alarmLed(alarmLed), .linkBaudSel(linkBaudSel), .linkSevenBits(linkSevenBits),
    .linkTwoStop(linkTwoStop), .linkParity(linkParity), .linkProtocol(linkProtocol),
    .linkAddress(linkAddress));
  prc_pulse_source src (.mclk(mclk), .period(period), .highCycles(highCycles),
    .pulseIn(pulseIn));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    rdat = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 100) miscompares++;
    @(posedge mclk);
  endtask
  task automatic waitUpd(input int n);
    repeat (n)
    begin
      k = 0;
      do
      begin
        @(negedge mclk);
        k++;
      end
      while (outUpdate !== 1'b1 && k < 30000);
      if (k >= 30000) miscompares++;
    end
    @(posedge mclk);
  endtask
  task automatic waitLed(input logic [1:0] want);
    k = 0;
    while (alarmLed !== want && k < 6000)
    begin
      @(negedge mclk);
      k++;
    end
    @(posedge mclk);
  endtask
  task automatic results();
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    #600000;
    miscompares++;
    results();
  end
  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    period = 16'h0000;
    highCycles = 16'h0000;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    check("link config", {linkAddress, linkProtocol, linkParity, linkTwoStop, linkSevenBits,
      linkBaudSel}, 32'h0000_0113);
    for (i = 0; i < 8; i++)
    begin
      apb(1'b0, rstAddr[i], 32'h0000_0000);
      check("reset value", rdat, rstVal[i]);
    end
    check("unmapped error", lastErr, 1'b1);
    period <= 16'h0FA0;
    highCycles <= 16'h04B0;
    for (i = 0; i < 8; i++)
    begin
      apb(1'b1, dirAddr[i], dirVal[i]);
      waitUpd(2);
      check("direct level", outLevel, dirLevel[i]);
    end
    apb(1'b0, `PRC_MEASFREQ, 32'h0000_0000);
    check("measured freq", rdat, 32'h004C_4B40);
    apb(1'b1, `PRC_ALMSET, 32'h0258_0190);
    apb(1'b1, `PRC_CTRL, 32'h0001_1328);
    waitLed(2'b11);
    check("alarm leds", alarmLed, 2'b11);
    check("relay drive", relayDrive, 2'b10);
    period <= 16'h148F;
    waitUpd(2);
    repeat (600) @(posedge mclk);
    check("alarm in band", alarmLed, 2'b11);
    period <= 16'h1770;
    waitLed(2'b10);
    check("alarm cleared", alarmLed, 2'b10);
    check("relay normal", relayDrive, 2'b11);
    apb(1'b1, `PRC_ALMONDLY, 32'h0000_0001);
    period <= 16'h0FA0;
    j = 0;
    do
      waitUpd(1);
    while (outLevel < 16'h0190 && j++ < 10);
    t0 = cyc;
    waitLed(2'b11);
    check("on delay", (cyc - t0 >= 2150) && (cyc - t0 <= 2450), 1'b1);
    apb(1'b1, `PRC_SAMPTIME, 32'h0000_0002);
    period <= 16'h0064;
    highCycles <= 16'h001E;
    for (i = 0; i < 3; i++)
    begin
      apb(1'b1, `PRC_CTRL, intCtrl[i]);
      apb(1'b1, `PRC_FULLFREQ, intFull[i]);
      waitUpd(3);
      t0 = cyc;
      waitUpd(1);
      check("sample ticks", (cyc - t0 + 100) / 200, intTicks[i]);
      apb(1'b0, `PRC_MEASFREQ, 32'h0000_0000);
      check("average freq", rdat, 32'h0000_07D0);
      check("integrated level", outLevel, intLevel[i]);
    end
    apb(1'b1, `PRC_CTRL, 32'h0001_132F);
    for (i = 0; i < 2; i++)
    begin
      highCycles <= (i != 0) ? 16'h000A : 16'h001E;
      waitUpd(3);
      apb(1'b0, `PRC_MEASFREQ, 32'h0000_0000);
      check("filtered freq", rdat, (i != 0) ? 32'h0000_0000 : 32'h0000_07D0);
    end
    results();
  end
endmodule
